// >>> fan_pkg.sv
// Purpose: Shared constants and carrier types for the automatic fan duty ramp.
// Assumes: Byte-wide register port, one 250 MHz clock, three channels, three outputs.
// Notes:   Channel index 0 is remote 1, 1 is local, 2 is remote 2.
//
// Operation
// RQ1: With its floor-hold bit clear, an output is driven at zero duty below start minus hysteresis, bits 7, 6 and 5 serving outputs three, two and one.
// RQ2: With its floor-hold bit set, an output stays at its floor duty below start minus hysteresis.
// RQ3: Once the temperature rises above the start temperature, each output starts at its own floor duty.
// RQ4: Each floor duty is an 8-bit value from zero to full duty, about 0.39% per count.
// RQ5: All three floor duty settings reset to 0x80, half duty.
// RQ6: A duty code of 255 is full drive and the computed duty never goes beyond it.
// RQ7: Above the start temperature the duty rises linearly, reaching full duty at start plus (255 minus floor) times span over 170.
// RQ8: Each channel has its own ramp-span register, remote one at 0x5F, local at 0x60 and remote two at 0x61.
// RQ9: The span code in bits 7 to 4 selects 2 to 80 degrees from a fixed table, code 1100 (32 degrees) by default.
// RQ10: Outputs that follow one channel switch on at the same start temperature, each with its own floor duty.
// RQ11: Each channel start temperature is an 8-bit two's complement value in one degree steps.
// RQ12: Once on, a fan stays on until the temperature falls below start minus hysteresis.
// RQ13: Duty is floor plus (temperature minus start) times 170 over span, rounded down and saturated at 255.
// RQ14: The duty is recomputed whenever a new measurement of the controlling channel arrives.
package fan_pkg;
   localparam int NUM_CHAN = 3;
   localparam int NUM_OUT  = 3;

   // Register offsets.
   localparam logic [7:0] ADDR_DUTY1     = 8'h30;
   localparam logic [7:0] ADDR_DUTY2     = 8'h31;
   localparam logic [7:0] ADDR_DUTY3     = 8'h32;
   localparam logic [7:0] ADDR_RAMP_R1   = 8'h5F;
   localparam logic [7:0] ADDR_RAMP_LOC  = 8'h60;
   localparam logic [7:0] ADDR_RAMP_R2   = 8'h61;
   localparam logic [7:0] ADDR_HOLD      = 8'h62;
   localparam logic [7:0] ADDR_FLOOR1    = 8'h64;
   localparam logic [7:0] ADDR_FLOOR2    = 8'h65;
   localparam logic [7:0] ADDR_FLOOR3    = 8'h66;
   localparam logic [7:0] ADDR_TMIN_R1   = 8'h67;
   localparam logic [7:0] ADDR_TMIN_LOC  = 8'h68;
   localparam logic [7:0] ADDR_TMIN_R2   = 8'h69;
   localparam logic [7:0] ADDR_HYST_A    = 8'h6D;
   localparam logic [7:0] ADDR_HYST_B    = 8'h6E;

   // Reset values.
   localparam logic [7:0] RST_RAMP       = 8'hC0;
   localparam logic [7:0] RST_HOLD       = 8'h00;
   localparam logic [7:0] RST_FLOOR      = 8'h80;
   localparam logic [7:0] RST_TMIN       = 8'h5A;
   localparam logic [7:0] RST_HYST_A     = 8'h44;
   localparam logic [7:0] RST_HYST_B     = 8'h40;
   localparam logic [7:0] RD_UNMAPPED    = 8'h00;

   // Field positions and duty codes.
   localparam int         RAMP_CODE_LSB  = 4;
   localparam int         HOLD_BIT_LSB   = 5;
   localparam int         HYST_HI_LSB    = 4;
   localparam int         SLOPE_FRAC     = 4;
   localparam logic [7:0] DUTY_OFF       = 8'h00;
   localparam logic [7:0] DUTY_FULL      = 8'hFF;
   localparam logic [7:0] PWM_LAST_STEP  = 8'hFE;
   localparam int         PWM_PRESCALE   = 1;

   // Duty counts per degree, 170 over span, times 2**SLOPE_FRAC; every entry is exact.
   localparam logic [10:0] RAMP_SLOPE16 [16] = '{
      11'h550, 11'h440, 11'h330, 11'h2A8, 11'h220, 11'h198, 11'h154, 11'h110,
      11'h0CC, 11'h0AA, 11'h088, 11'h066, 11'h055, 11'h044, 11'h033, 11'h022};

   typedef struct packed {
      logic       valid;   // One-cycle pulse: a new reading is present.
      logic [7:0] value;   // Two's complement degrees.
   } temp_sample_s;

   typedef struct packed {
      logic [7:0]  tmin;   // Two's complement start temperature.
      logic [3:0]  hyst;   // Hysteresis in degrees.
      logic [10:0] slope;  // Duty per degree with SLOPE_FRAC fraction bits.
   } chan_cfg_s;
endpackage

// >>> fan_duty_calc.sv
// Purpose: Per-output duty computation with on/off hysteresis.
// Assumes: Reading and configuration come from logic on the same clock.
// Notes:   Duty and on state change only on a reading of the followed channel.
`timescale 1ns/100ps
module fan_duty_calc (
   input  wire logic               mclk,     // Block clock.
   input  wire logic               rst_n,    // Synchronous reset, active low.
   input  wire logic               ce,       // Clock enable, freezes state when low.
   input  wire fan_pkg::temp_sample_s temp,  // Reading of the followed channel.
   input  wire fan_pkg::chan_cfg_s cfg,      // Settings of the followed channel.
   input  wire logic [7:0]         floor,    // Floor duty of this output.
   input  wire logic               hold,     // Floor-hold bit of this output.
   output logic [7:0]              duty,     // Computed duty code.
   output logic                    fan_on    // Fan is in its on state.
);
   logic signed [9:0] t_ext;
   logic signed [9:0] diff;
   logic signed [9:0] off_level;
   logic              above;
   logic              below;
   logic [18:0]       prod;
   logic [15:0]       sum;
   logic [7:0]        ramp_duty;
   logic              next_on;

   // Compare against start and start minus hysteresis in ten bits so nothing wraps.
   assign t_ext     = $signed({{2{temp.value[7]}}, temp.value});
   assign diff      = t_ext - $signed({{2{cfg.tmin[7]}}, cfg.tmin});     // [RQ11]
   assign off_level = $signed({{2{cfg.tmin[7]}}, cfg.tmin}) - $signed({6'h00, cfg.hyst});
   assign above     = diff > 10'sd0;
   assign below     = t_ext < off_level;

   // Linear ramp from the floor; the slope does not depend on the floor.
   assign prod      = diff[7:0] * cfg.slope;                              // [RQ7]
   assign sum       = {8'h00, floor} + {1'b0, prod[18:fan_pkg::SLOPE_FRAC]};   // [RQ13]
   assign ramp_duty = (sum > {8'h00, fan_pkg::DUTY_FULL}) ? fan_pkg::DUTY_FULL : sum[7:0]; // [RQ6]

   // On above start, off below start minus hysteresis, unchanged in the band.
   always_comb begin
      next_on = fan_on;
      if (above) begin
         next_on = 1'b1;
      end else if (below) begin
         next_on = 1'b0;                                                 // [RQ12]
      end
   end

   // On-state register, advanced only by a fresh reading.
   always_ff @(posedge mclk) begin
      if (!rst_n) begin
         fan_on <= 1'b0;
      end else if (ce && temp.valid) begin                               // [RQ14]
         fan_on <= next_on;
      end
   end

   // Duty register; in the hysteresis band a running fan stays at its floor.
   always_ff @(posedge mclk) begin
      if (!rst_n) begin
         duty <= fan_pkg::DUTY_OFF;
      end else if (ce && temp.valid) begin
         if (above) begin
            duty <= ramp_duty;                                           // [RQ3]
         end else if (next_on || hold) begin
            duty <= floor;                                               // [RQ2]
         end else begin
            duty <= fan_pkg::DUTY_OFF;                                   // [RQ1]
         end
      end
   end

   property p_off_zero;
      @(posedge mclk) disable iff (!rst_n)
      (ce && temp.valid && below && !hold) |=> (duty == fan_pkg::DUTY_OFF && !fan_on);
   endproperty
   a_off_zero: assert property (p_off_zero) else $error("Duty not zero below off level."); // [RQ1]

   property p_hold_floor;
      @(posedge mclk) disable iff (!rst_n)
      (ce && temp.valid && below && hold) |=> (duty == $past(floor));
   endproperty
   a_hold_floor: assert property (p_hold_floor) else $error("Held duty differs from floor."); // [RQ2]

   property p_start_floor;
      @(posedge mclk) disable iff (!rst_n)
      (ce && temp.valid && above) |=> (duty >= $past(floor) && fan_on);
   endproperty
   a_start_floor: assert property (p_start_floor) else $error("Duty below floor when hot."); // [RQ3]

   property p_saturate;
      @(posedge mclk) disable iff (!rst_n)
      (ce && temp.valid && above && sum > 16'h00FF) |=> (duty == fan_pkg::DUTY_FULL);
   endproperty
   a_saturate: assert property (p_saturate) else $error("Duty not saturated at full."); // [RQ6]

   property p_band_keeps;
      @(posedge mclk) disable iff (!rst_n)
      (ce && temp.valid && fan_on && !above && !below) |=> (fan_on && duty == $past(floor));
   endproperty
   a_band_keeps: assert property (p_band_keeps) else $error("Fan left on state in band."); // [RQ12]

   property p_only_on_reading;
      @(posedge mclk) disable iff (!rst_n)
      !(ce && temp.valid) |=> ($stable(duty) && $stable(fan_on));
   endproperty
   a_only_on_reading: assert property (p_only_on_reading) else $error("Duty moved without reading."); // [RQ14]
endmodule

// >>> fan_auto_duty_ramp.sv
// Purpose: Automatic fan duty ramp for three pulse-width fan outputs.
// Assumes: Readings arrive as one-cycle strobes from the measurement logic on mclk.
// Notes:   Register port is a plain byte port; reads answer one cycle later.
`timescale 1ns/100ps
module fan_auto_duty_ramp #(
   parameter int PRESCALE = fan_pkg::PWM_PRESCALE  // Clocks per waveform step.
) (
   input  wire logic               mclk,          // Block clock, 250 MHz.
   input  wire logic               rst_n,         // Synchronous reset, active low.
   input  wire logic               ce,            // Clock enable, freezes state when low.
   input  wire logic               reg_wr,        // Register write strobe.
   input  wire logic               reg_rd,        // Register read strobe.
   input  wire logic [7:0]         reg_addr,      // Register offset.
   input  wire logic [7:0]         reg_wdata,     // Write data.
   output logic [7:0]              reg_rdata,     // Read data, one cycle after reg_rd.
   input  wire fan_pkg::temp_sample_s [2:0] temp_in,  // Readings, index is channel.
   input  wire logic [5:0]         out_chan_sel,  // Two bits per output: followed channel.
   output logic                    fan_drive_out1, // Waveform for output one.
   output logic                    fan_drive_out2, // Waveform for output two.
   output logic                    fan_drive_out3  // Waveform for output three.
);
   localparam int PRE_W = (PRESCALE > 1) ? $clog2(PRESCALE) : 1;
   localparam logic [PRE_W-1:0] PRE_LAST = PRE_W'(PRESCALE - 1);

   logic [7:0]  ramp_cfg [fan_pkg::NUM_CHAN];
   logic [7:0]  floor_duty [fan_pkg::NUM_OUT];
   logic [7:0]  tmin [fan_pkg::NUM_CHAN];
   logic [7:0]  floor_hold;
   logic [7:0]  hyst_a;
   logic [7:0]  hyst_b;
   logic [3:0]  hyst [fan_pkg::NUM_CHAN];
   logic [10:0] slope_sel [fan_pkg::NUM_CHAN];
   logic [7:0]  duty [fan_pkg::NUM_OUT];
   logic [2:0]  fan_on;
   logic [PRE_W-1:0] pre_cnt;
   logic [7:0]  step_cnt;
   logic [2:0]  drive_q;
   logic [7:0]  next_rdata;
   logic [5:0]  sel_meta;
   logic [5:0]  sel_sync;
   logic [5:0]  sel_last;
   logic [5:0]  sel_q;

   // Hysteresis nibbles: remote 1 high and local low of one byte, remote 2 high of another.
   assign hyst[0] = hyst_a[fan_pkg::HYST_HI_LSB +: 4];
   assign hyst[1] = hyst_a[3:0];
   assign hyst[2] = hyst_b[fan_pkg::HYST_HI_LSB +: 4];

   // Span code to slope lookup, one per channel.
   always_comb begin
      for (int c = 0; c < fan_pkg::NUM_CHAN; c++) begin
         slope_sel[c] = fan_pkg::RAMP_SLOPE16[ramp_cfg[c][fan_pkg::RAMP_CODE_LSB +: 4]]; // [RQ9]
      end
   end

   // Ramp-span registers, one per channel.
   always_ff @(posedge mclk) begin
      if (!rst_n) begin
         for (int c = 0; c < fan_pkg::NUM_CHAN; c++) begin
            ramp_cfg[c] <= fan_pkg::RST_RAMP;                            // [RQ9]
         end
      end else if (ce && reg_wr) begin
         unique case (reg_addr)
            fan_pkg::ADDR_RAMP_R1:  ramp_cfg[0] <= reg_wdata;            // [RQ8]
            fan_pkg::ADDR_RAMP_LOC: ramp_cfg[1] <= reg_wdata;            // [RQ8]
            fan_pkg::ADDR_RAMP_R2:  ramp_cfg[2] <= reg_wdata;            // [RQ8]
            default: ;
         endcase
      end
   end

   // Floor duty registers; a full byte, so 0 to 255 covers off to full drive.
   always_ff @(posedge mclk) begin
      if (!rst_n) begin
         for (int o = 0; o < fan_pkg::NUM_OUT; o++) begin
            floor_duty[o] <= fan_pkg::RST_FLOOR;                         // [RQ5]
         end
      end else if (ce && reg_wr) begin
         unique case (reg_addr)
            fan_pkg::ADDR_FLOOR1: floor_duty[0] <= reg_wdata;            // [RQ4]
            fan_pkg::ADDR_FLOOR2: floor_duty[1] <= reg_wdata;            // [RQ4]
            fan_pkg::ADDR_FLOOR3: floor_duty[2] <= reg_wdata;            // [RQ4]
            default: ;
         endcase
      end
   end

   // Start temperatures, two's complement degrees.
   always_ff @(posedge mclk) begin
      if (!rst_n) begin
         for (int c = 0; c < fan_pkg::NUM_CHAN; c++) begin
            tmin[c] <= fan_pkg::RST_TMIN;
         end
      end else if (ce && reg_wr) begin
         unique case (reg_addr)
            fan_pkg::ADDR_TMIN_R1:  tmin[0] <= reg_wdata;                // [RQ11]
            fan_pkg::ADDR_TMIN_LOC: tmin[1] <= reg_wdata;                // [RQ11]
            fan_pkg::ADDR_TMIN_R2:  tmin[2] <= reg_wdata;                // [RQ11]
            default: ;
         endcase
      end
   end

   // Floor-hold and hysteresis bytes; the spare bits are kept for other functions.
   always_ff @(posedge mclk) begin
      if (!rst_n) begin
         floor_hold <= fan_pkg::RST_HOLD;
         hyst_a     <= fan_pkg::RST_HYST_A;
         hyst_b     <= fan_pkg::RST_HYST_B;
      end else if (ce && reg_wr) begin
         unique case (reg_addr)
            fan_pkg::ADDR_HOLD:   floor_hold <= reg_wdata;
            fan_pkg::ADDR_HYST_A: hyst_a     <= reg_wdata;
            fan_pkg::ADDR_HYST_B: hyst_b     <= reg_wdata;
            default: ;
         endcase
      end
   end

   // The channel select comes from board pins, so it passes three flops. A new code is
   // taken only once the last two agree, so no output acts on a half-changed code.
   always_ff @(posedge mclk) begin
      if (!rst_n) begin
         sel_meta <= 6'h00;
         sel_sync <= 6'h00;
         sel_last <= 6'h00;
         sel_q    <= 6'h00;
      end else if (ce) begin
         sel_meta <= out_chan_sel;
         sel_sync <= sel_meta;
         sel_last <= sel_sync;
         if (sel_sync == sel_last) begin
            sel_q <= sel_last;
         end
      end
   end

   // One duty calculator per output. Outputs sharing a channel see the same start
   // temperature but keep their own floor and hold bit.
   for (genvar o = 0; o < fan_pkg::NUM_OUT; o++) begin : g_out
      logic [1:0]            sel;
      logic [1:0]            ch;
      fan_pkg::temp_sample_s sample;
      fan_pkg::chan_cfg_s    cfg;

      // An unused select code of 3 falls back to remote 1 rather than stalling.
      assign sel    = sel_q[2*o +: 2];
      assign ch     = (sel == 2'h3) ? 2'h0 : sel;
      assign sample = temp_in[ch];                                       // [RQ10]
      assign cfg    = '{tmin: tmin[ch], hyst: hyst[ch], slope: slope_sel[ch]}; // [RQ10]

      fan_duty_calc u_calc (
         .mclk   (mclk),
         .rst_n  (rst_n),
         .ce     (ce),
         .temp   (sample),
         .cfg    (cfg),
         .floor  (floor_duty[o]),
         .hold   (floor_hold[fan_pkg::HOLD_BIT_LSB + o]),                // [RQ1]
         .duty   (duty[o]),
         .fan_on (fan_on[o])
      );
   end

   // Read mux; current duties are readable so software can watch the loop.
   always_comb begin
      unique case (reg_addr)
         fan_pkg::ADDR_DUTY1:    next_rdata = duty[0];
         fan_pkg::ADDR_DUTY2:    next_rdata = duty[1];
         fan_pkg::ADDR_DUTY3:    next_rdata = duty[2];
         fan_pkg::ADDR_RAMP_R1:  next_rdata = ramp_cfg[0];
         fan_pkg::ADDR_RAMP_LOC: next_rdata = ramp_cfg[1];
         fan_pkg::ADDR_RAMP_R2:  next_rdata = ramp_cfg[2];
         fan_pkg::ADDR_HOLD:     next_rdata = floor_hold;
         fan_pkg::ADDR_FLOOR1:   next_rdata = floor_duty[0];
         fan_pkg::ADDR_FLOOR2:   next_rdata = floor_duty[1];
         fan_pkg::ADDR_FLOOR3:   next_rdata = floor_duty[2];
         fan_pkg::ADDR_TMIN_R1:  next_rdata = tmin[0];
         fan_pkg::ADDR_TMIN_LOC: next_rdata = tmin[1];
         fan_pkg::ADDR_TMIN_R2:  next_rdata = tmin[2];
         fan_pkg::ADDR_HYST_A:   next_rdata = hyst_a;
         fan_pkg::ADDR_HYST_B:   next_rdata = hyst_b;
         default:                next_rdata = fan_pkg::RD_UNMAPPED;
      endcase
   end

   // Read data is registered so the port comes straight from a flip-flop.
   always_ff @(posedge mclk) begin
      if (!rst_n) begin
         reg_rdata <= fan_pkg::RD_UNMAPPED;
      end else if (ce && reg_rd) begin
         reg_rdata <= next_rdata;
      end
   end

   // Waveform step counter. The period is 255 steps, so a code of 255 is high in
   // every step and a code of 0 in none.
   always_ff @(posedge mclk) begin
      if (!rst_n) begin
         pre_cnt  <= '0;
         step_cnt <= 8'h00;
      end else if (ce) begin
         if (pre_cnt == PRE_LAST) begin
            pre_cnt  <= '0;
            step_cnt <= (step_cnt == fan_pkg::PWM_LAST_STEP) ? 8'h00 : step_cnt + 8'h01;
         end else begin
            pre_cnt <= pre_cnt + 1'b1;
         end
      end
   end

   // Drive outputs, compared against the live duty so a change shows on the next clock.
   always_ff @(posedge mclk) begin
      if (!rst_n) begin
         drive_q <= 3'h0;
      end else if (ce) begin
         for (int o = 0; o < fan_pkg::NUM_OUT; o++) begin
            drive_q[o] <= (step_cnt < duty[o]);                          // [RQ6]
         end
      end
   end

   assign fan_drive_out1 = drive_q[0];
   assign fan_drive_out2 = drive_q[1];
   assign fan_drive_out3 = drive_q[2];

   property p_floor_reset;
      @(posedge mclk) disable iff (!rst_n)
      $rose(rst_n) |-> (floor_duty[0] == 8'h80 && floor_duty[1] == 8'h80
                        && floor_duty[2] == 8'h80);
   endproperty
   a_floor_reset: assert property (p_floor_reset) else $error("Floor duty reset wrong."); // [RQ5]

   property p_floor_write;
      @(posedge mclk) disable iff (!rst_n)
      (ce && reg_wr && reg_addr == 8'h65) |=> (floor_duty[1] == $past(reg_wdata));
   endproperty
   a_floor_write: assert property (p_floor_write) else $error("Floor duty write lost."); // [RQ4]

   property p_span_select;
      @(posedge mclk) disable iff (!rst_n)
      (ce && reg_wr && reg_addr == 8'h60)
         |=> (slope_sel[1] == fan_pkg::RAMP_SLOPE16[$past(reg_wdata[7:4])]);
   endproperty
   a_span_select: assert property (p_span_select) else $error("Span code not applied."); // [RQ9]

   property p_span_own;
      @(posedge mclk) disable iff (!rst_n)
      (ce && reg_wr && reg_addr == 8'h61) |=> (ramp_cfg[0] == $past(ramp_cfg[0]));
   endproperty
   a_span_own: assert property (p_span_own) else $error("Span write hit wrong channel."); // [RQ8]

   property p_full_drive;
      @(posedge mclk) disable iff (!rst_n)
      (ce && duty[0] == 8'hFF) |=> fan_drive_out1;
   endproperty
   a_full_drive: assert property (p_full_drive) else $error("Full duty did not drive high."); // [RQ6]

   property p_zero_drive;
      @(posedge mclk) disable iff (!rst_n)
      (ce && duty[2] == 8'h00) |=> !fan_drive_out3;
   endproperty
   a_zero_drive: assert property (p_zero_drive) else $error("Zero duty drove high."); // [RQ1]

   property p_shared_start;
      @(posedge mclk) disable iff (!rst_n)
      (ce && sel_q[1:0] == sel_q[3:2] && g_out[0].sample.valid
         && fan_on[0] == fan_on[1]) |=> (fan_on[0] == fan_on[1]);
   endproperty
   a_shared_start: assert property (p_shared_start) else $error("Shared channel split on."); // [RQ10]

   property p_sel_agree;
      @(posedge mclk) disable iff (!rst_n)
      (ce && sel_sync != sel_last) |=> $stable(sel_q);
   endproperty
   a_sel_agree: assert property (p_sel_agree) else $error("Select taken unsettled."); // [RQ10]
endmodule

// >>> fan_load.sv
// Purpose: Fan load model that integrates the drive seen on one fan output.
// Assumes: The drive waveform repeats every 255 clocks.
// Notes:   A fan gives nothing back to the block, so the model only listens.
`timescale 1ns/100ps
module fan_load (
   input  wire logic       mclk,   // Block clock.
   input  wire logic       drive,  // Fan drive waveform.
   input  wire logic       start,  // Begins one measurement window.
   output logic [7:0]      high,   // High clocks counted in the window.
   output logic            done    // Window has finished.
);
   logic [8:0] left;
   // Any 255 consecutive clocks visit every step once, so the count equals the duty.
   always_ff @(posedge mclk) begin
      if (start) begin
         left <= 9'h0FF;
         high <= 8'h00;
         done <= 1'b0;
      end else if (left != 9'h000) begin
         left <= left - 9'h001;
         high <= high + {7'h00, drive};
         done <= (left == 9'h001);
      end
   end
endmodule

// >>> fan_auto_duty_ramp_tb.sv
// Purpose: Self-checking bench for the automatic fan duty ramp.
// Assumes: Default PRESCALE, so one waveform period is 255 clocks.
// Notes:   Duty is checked both by readback and by the fan load models.
`timescale 1ns/100ps
`define CHK(got, want) begin \
   cmp_count++; \
   if ((got) !== (want)) begin \
      mismatches++; \
      $display("Error at %0t ns: got %h, expected %h", $time, got, want); \
   end \
end
module fan_auto_duty_ramp_tb;
   typedef struct packed {
      logic [7:0] floor;
      logic [3:0] code;
      logic [7:0] temp;
      logic [7:0] duty;
   } row_s;
   // Start 30 degrees; sixteen span codes at 31 degrees, then two ramp end points, two mid-ramp points and one saturated point.
   localparam row_s ROWS [21] = '{
      '{8'h00, 4'h0, 8'h1F, 8'h55}, '{8'h00, 4'h1, 8'h1F, 8'h44},
      '{8'h00, 4'h2, 8'h1F, 8'h33}, '{8'h00, 4'h3, 8'h1F, 8'h2A},
      '{8'h00, 4'h4, 8'h1F, 8'h22}, '{8'h00, 4'h5, 8'h1F, 8'h19},
      '{8'h00, 4'h6, 8'h1F, 8'h15}, '{8'h00, 4'h7, 8'h1F, 8'h11},
      '{8'h00, 4'h8, 8'h1F, 8'h0C}, '{8'h00, 4'h9, 8'h1F, 8'h0A},
      '{8'h00, 4'hA, 8'h1F, 8'h08}, '{8'h00, 4'hB, 8'h1F, 8'h06},
      '{8'h00, 4'hC, 8'h1F, 8'h05}, '{8'h00, 4'hD, 8'h1F, 8'h04},
      '{8'h00, 4'hE, 8'h1F, 8'h03}, '{8'h00, 4'hF, 8'h1F, 8'h02},
      '{8'h55, 4'hD, 8'h46, 8'hFF}, '{8'h80, 4'hD, 8'h3C, 8'hFF},
      '{8'h1A, 4'hD, 8'h32, 8'h6F}, '{8'h40, 4'hF, 8'h28, 8'h55},
      '{8'h80, 4'hD, 8'h7F, 8'hFF}};
   logic                         mclk;
   logic                         rst_n;
   logic                         reg_wr;
   logic                         reg_rd;
   logic [7:0]                   reg_addr;
   logic [7:0]                   reg_wdata;
   logic [7:0]                   reg_rdata;
   fan_pkg::temp_sample_s [2:0]  temp_in;
   logic [5:0]                   out_chan_sel;
   logic [2:0]                   drive;
   logic [2:0]                   start;
   logic [2:0]                   done;
   logic [7:0]                   high [3];
   logic                         ce;
   int                           mismatches;
   int                           cmp_count;

   fan_auto_duty_ramp dut (.mclk(mclk), .rst_n(rst_n), .ce(ce), .reg_wr(reg_wr),
      .reg_rd(reg_rd), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
      .temp_in(temp_in), .out_chan_sel(out_chan_sel), .fan_drive_out1(drive[0]),
      .fan_drive_out2(drive[1]), .fan_drive_out3(drive[2]));
   // One fan on each output, all measured independently.
   fan_load fan1 (.mclk(mclk), .drive(drive[0]), .start(start[0]), .high(high[0]), .done(done[0]));
   fan_load fan2 (.mclk(mclk), .drive(drive[1]), .start(start[1]), .high(high[1]), .done(done[1]));
   fan_load fan3 (.mclk(mclk), .drive(drive[2]), .start(start[2]), .high(high[2]), .done(done[2]));

   // Free-running 250 MHz clock.
   initial begin
      mclk = 1'b0;
      forever #2 mclk = ~mclk;
   end

   task automatic summarize();
      $display("Comparisons %0d, mismatches %0d", cmp_count, mismatches);
      if (mismatches == 0 && cmp_count > 0) begin
         $display("STATUS OK");
      end else begin
         $display("STATUS NOT OK");
      end
      $finish;
   endtask
   // Inputs move 1 ns after the edge so the design never races the bench.
   task automatic tick();
      @(posedge mclk);
      #1;
   endtask
   // The idle cycle after each strobe keeps a driver from assigning twice in one step.
   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      reg_wr = 1'b1;
      reg_addr = a;
      reg_wdata = d;
      tick();
      reg_wr = 1'b0;
      tick();
   endtask
   task automatic chk_reg(input logic [7:0] a, input logic [7:0] want);
      reg_rd = 1'b1;
      reg_addr = a;
      tick();
      reg_rd = 1'b0;
      `CHK(reg_rdata, want)
      tick();
   endtask
   task automatic sample(input int ch, input logic [7:0] t);
      temp_in[ch] = {1'b1, t};
      tick();
      temp_in[ch] = 9'h000;
      tick();
      tick();
   endtask
   task automatic chk_fan(input int o, input logic [7:0] want);
      start[o] = 1'b1;
      tick();
      start[o] = 1'b0;
      for (int n = 0; n < 300 && done[o] !== 1'b1; n++) tick();
      if (done[o] !== 1'b1) begin
         mismatches++;
         summarize();
      end else begin
         `CHK(high[o], want)
      end
   endtask

   // Main sequence: reset, table rows, then the hysteresis and selection cases.
   initial begin
      rst_n = 1'b0;
      ce = 1'b1;
      {reg_wr, reg_rd, reg_addr, reg_wdata, temp_in, out_chan_sel, start} = '0;
      repeat (8) tick();
      rst_n = 1'b1;
      tick();
      for (int a = 8'h64; a < 8'h67; a++) chk_reg(8'(a), 8'h80);
      for (int a = 8'h5F; a < 8'h62; a++) chk_reg(8'(a), 8'hC0);
      chk_reg(8'h62, 8'h00);
      chk_reg(8'h70, 8'h00);
      chk_fan(0, 8'h00);
      for (int a = 8'h5F; a < 8'h62; a++) wr(8'(a), 8'(a));
      for (int a = 8'h5F; a < 8'h62; a++) chk_reg(8'(a), 8'(a));
      wr(8'h61, 8'hC0);
      wr(8'h67, 8'h1E);
      for (int i = 0; i < 21; i++) begin
         wr(8'h64, ROWS[i].floor);
         wr(8'h5F, {ROWS[i].code, 4'h0});
         sample(0, ROWS[i].temp);
         chk_reg(8'h30, ROWS[i].duty);
         chk_fan(0, ROWS[i].duty);
      end
      wr(8'h64, 8'h80);
      wr(8'h66, 8'h20);
      wr(8'h5F, 8'hC0);
      sample(0, 8'h1F);
      chk_reg(8'h30, 8'h85);
      chk_reg(8'h31, 8'h85);
      chk_fan(1, 8'h85);
      chk_reg(8'h32, 8'h25);
      sample(0, 8'h1B);
      chk_reg(8'h30, 8'h80);
      sample(0, 8'h19);
      chk_reg(8'h30, 8'h00);
      chk_fan(2, 8'h00);
      sample(0, 8'h1B);
      chk_reg(8'h30, 8'h00);
      wr(8'h62, 8'hE0);
      sample(0, 8'h19);
      chk_reg(8'h30, 8'h80);
      chk_fan(2, 8'h20);
      wr(8'h62, 8'h80);
      sample(0, 8'h19);
      chk_reg(8'h30, 8'h00);
      chk_reg(8'h32, 8'h20);
      out_chan_sel = 6'h20;
      repeat (4) tick(); // The select pin needs four edges to settle.
      sample(2, 8'h5B);
      chk_reg(8'h32, 8'h25);
      chk_reg(8'h30, 8'h00);
      wr(8'h62, 8'h00);
      wr(8'h67, 8'hF6);
      wr(8'h64, 8'h00);
      wr(8'h5F, 8'h00);
      sample(0, 8'hF7);
      chk_reg(8'h30, 8'h55);
      ce = 1'b0;
      wr(8'h65, 8'h11);
      ce = 1'b1;
      chk_reg(8'h65, 8'h80);
      wr(8'h65, 8'h40);
      chk_reg(8'h65, 8'h40);
      rst_n = 1'b0;
      tick();
      rst_n = 1'b1;
      tick();
      chk_reg(8'h65, 8'h80);
      chk_reg(8'h32, 8'h00);
      summarize();
   end
endmodule
